// ### rtl/tsf_top.sv
// Function
// [R1] ch1/2 bit7 shows direction, ch0 zero
// [R2] bit6 of every status reads one
// [R3] phase mode: zero to max sets underflow
// [R4] ch0 underflow bit reads zero, fixed
// [R5] max to zero wrap sets overflow
// [R6] write zero after reading one clears
// [R7] ch0 compare match on d sets flag
// [R8] ch0 capture into d sets flag
// [R9] ch1/2 bit3 reads zero, fixed
// [R10] ch0 compare match on c sets flag
// [R11] ch0 capture into c sets flag
// [R12] ch1/2 bit2 reads zero, fixed
// [R13] compare match on b sets flag
// [R14] capture into b sets flag
// [R15] compare match on a sets flag
// [R16] capture into a sets flag
// [R17] one status register per channel
// [R18] three 16-bit counters, reset to zero
// [R19] counter takes only full 16-bit writes
// [R20] enabled set flag raises interrupt request
// [R21] counter counts only while run set
// [R22] set event beats clearing write
// [R23] phase mode wraps both ways, flagged
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tsf_defs.svh"

module tsf_top
  import tsf_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] count_step,
  input wire logic [2:0] count_up,
  input wire logic [11:0] match_strobe,
  input wire logic [11:0] capture_strobe,
  input wire logic [11:0] capture_mode,
  output logic [47:0] count_value,
  output logic [23:0] event_status,
  output logic [17:0] irq_request
);

  logic [1:0] rst_sync_q;
  logic rst_n;

  // release through two flops so no flop sees a ragged deassert
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_q[1];

  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic awready_q, wready_q;
  logic bvalid_q, bvalid_d;
  logic arready_q;
  logic rvalid_q, rvalid_d;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [5:0] ctrl_q;

  // write channel handshakes; address and data may come in either order
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire do_write = aw_held_q & w_held_q & ~bvalid_q;

  assign aw_held_d = ~do_write & (aw_held_q | aw_take);
  assign w_held_d = ~do_write & (w_held_q | w_take);
  assign bvalid_d = do_write | (bvalid_q & ~s_axi_bready);

  // read channel; only one read under way, so arready falls while rvalid stands
  wire ar_take = s_axi_arvalid & arready_q;

  assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);

  // address decode of both channels shares one function
  tsf_reg_e wr_reg;
  tsf_reg_e rd_reg;

  assign wr_reg = tsf_reg_of(aw_addr_q);
  assign rd_reg = tsf_reg_of(s_axi_araddr);

  // [R19] counter needs both low lanes
  wire wr_cnt = (wr_reg == TSF_R_CNT0) | (wr_reg == TSF_R_CNT1) | (wr_reg == TSF_R_CNT2);
  wire wr_word = &w_strb_q[1:0];
  wire wr_err = (wr_reg == TSF_R_NONE) | (wr_cnt & ~wr_word);
  wire wr_ok = do_write & ~wr_err & (wr_cnt | w_strb_q[0]); // byte regs need lane 0

  // write handshake flops; ready stays low while a response is pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'h0;
      w_held_q <= 1'h0;
      awready_q <= 1'h0;
      wready_q <= 1'h0;
      bvalid_q <= 1'h0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= ~aw_held_d & ~bvalid_d;
      wready_q <= ~w_held_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
    end
  end

  // write payload capture and response code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr_q <= 32'h00000000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= `TSF_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_q <= wr_err ? `TSF_RESP_SLVERR : `TSF_RESP_OKAY;
      end
    end
  end

  // [R21] run and phase mode bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `TSF_CTRL_RST;
    end else if (wr_ok && wr_reg == TSF_R_CTRL) begin
      ctrl_q <= w_data_q[5:0] & `TSF_CTRL_MASK;
    end
  end

  // read table indexed by selector code
  logic [31:0] rd_table [10];
  logic [31:0] rd_word;

  assign rd_table[6] = {26'h0, ctrl_q};
  assign rd_word = (rd_reg == TSF_R_NONE) ? 32'h00000000 : rd_table[rd_reg];

  logic [7:0] stat_w [3];
  logic [15:0] cnt_w [3];
  logic [5:0] irq_w [3];

  // [R17] one slice per channel
  genvar gc;
  for (gc = 0; gc < 3; gc++) begin : g_ch
    localparam tsf_reg_e STAT_REG = tsf_reg_e'(4'(gc));
    localparam tsf_reg_e CNT_REG = tsf_reg_e'(4'(gc + 3));
    localparam tsf_reg_e IEN_REG = tsf_reg_e'(4'(gc + 7));
    localparam logic [5:0] MASK = (gc == 0) ? `TSF_CH0_MASK : `TSF_CH12_MASK;

    logic [5:0] ien_q;

    // a status read arms the flags that read back as one
    wire stat_rd = ar_take & (rd_reg == STAT_REG);
    wire stat_wr = wr_ok & (wr_reg == STAT_REG);
    wire cnt_wr = wr_ok & (wr_reg == CNT_REG);

    // [R20] enable bits, reserved ones held zero
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ien_q <= 6'h00;
      end else if (wr_ok && wr_reg == IEN_REG) begin
        ien_q <= w_data_q[5:0] & MASK;
      end
    end

    tsf_channel #(
      .HAS_PHASE(gc != 0),
      .FLAG_MASK(MASK)
    ) u_ch (
      .clk(clk),
      .rst_n(rst_n),
      .run(ctrl_q[gc]),
      .phase_en(ctrl_q[`TSF_CTRL_PHASE_LSB + gc]),
      .dir_up(count_up[gc]),
      .step(count_step[gc]),
      .match(match_strobe[gc*4 +: 4]),
      .capture(capture_strobe[gc*4 +: 4]),
      .cap_mode(capture_mode[gc*4 +: 4]),
      .cnt_wr(cnt_wr),
      .cnt_wdata(w_data_q[15:0]),
      .stat_rd(stat_rd),
      .stat_wr(stat_wr),
      .stat_wdata(w_data_q[5:0]),
      .irq_en(ien_q),
      .count(cnt_w[gc]),
      .status(stat_w[gc]),
      .irq(irq_w[gc])
    );

    // register views for the read path
    assign rd_table[gc] = {24'h0, stat_w[gc]};
    assign rd_table[gc + 3] = {16'h0, cnt_w[gc]};
    assign rd_table[gc + 7] = {26'h0, ien_q};

    // flop outputs of the slice straight to the pins
    assign count_value[gc*16 +: 16] = cnt_w[gc];
    assign event_status[gc*8 +: 8] = stat_w[gc];
    assign irq_request[gc*6 +: 6] = irq_w[gc];
  end

  // read data is taken at the address handshake, so it matches what armed the flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h0;
      rdata_q <= 32'h00000000;
      rresp_q <= `TSF_RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= (rd_reg == TSF_R_NONE) ? `TSF_RESP_SLVERR : `TSF_RESP_OKAY;
      end
    end
  end

  // bus outputs, each from its flop
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // [R19] partial counter write refused
  cnt_word_a: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
    (do_write && wr_cnt && !wr_word) |=>
    (bvalid_q && bresp_q == `TSF_RESP_SLVERR))
    else $error("partial counter write not refused");

  // [R17] status read of channel 1 returns that channel
  stat_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
    (ar_take && rd_reg == TSF_R_STAT1) |=>
    (rvalid_q && rdata_q == {24'h0, $past(stat_w[1])}))
    else $error("status read from wrong channel");

endmodule : tsf_top

// ### shared/tsf_defs.svh
`ifndef TSF_DEFS_SVH
`define TSF_DEFS_SVH

// register byte offsets on the axi4-lite slave
`define TSF_OFF_STAT0 32'h00000000
`define TSF_OFF_STAT1 32'h00000004
`define TSF_OFF_STAT2 32'h00000008
`define TSF_OFF_CNT0 32'h0000000C
`define TSF_OFF_CNT1 32'h00000010
`define TSF_OFF_CNT2 32'h00000014
`define TSF_OFF_CTRL 32'h00000018
`define TSF_OFF_IEN0 32'h0000001C
`define TSF_OFF_IEN1 32'h00000020
`define TSF_OFF_IEN2 32'h00000024

// status byte field positions; flags a..d sit in bits 0..3
`define TSF_BIT_DIR 7
`define TSF_BIT_RSV 6
`define TSF_BIT_UNF 5
`define TSF_BIT_OVF 4

// control word: run bits 2:0, phase mode bits 5:4, bit 3 held zero
`define TSF_CTRL_PHASE_LSB 3

// reset values, limits and implemented-bit masks
`define TSF_CNT_RST 16'h0000
`define TSF_CNT_MAX 16'hFFFF
`define TSF_DIR_RST 1'h1
`define TSF_CTRL_RST 6'h00
`define TSF_CTRL_MASK 6'h37
`define TSF_CH0_MASK 6'h1F
`define TSF_CH12_MASK 6'h33
`define TSF_RESP_OKAY 2'h0
`define TSF_RESP_SLVERR 2'h2

`endif

// ### shared/tsf_pkg.sv
`include "tsf_defs.svh"

package tsf_pkg;

  // register selector; codes equal the word index of the map
  typedef enum logic [3:0] {
    TSF_R_STAT0 = 4'h0,
    TSF_R_STAT1 = 4'h1,
    TSF_R_STAT2 = 4'h2,
    TSF_R_CNT0 = 4'h3,
    TSF_R_CNT1 = 4'h4,
    TSF_R_CNT2 = 4'h5,
    TSF_R_CTRL = 4'h6,
    TSF_R_IEN0 = 4'h7,
    TSF_R_IEN1 = 4'h8,
    TSF_R_IEN2 = 4'h9,
    TSF_R_NONE = 4'hF
  } tsf_reg_e;

  typedef logic [15:0] tsf_cnt_t;

  // full-address decode; anything unaligned or outside the map is none
  function automatic tsf_reg_e tsf_reg_of(input logic [31:0] addr);
    tsf_reg_e r;
    r = TSF_R_NONE;
    case (addr)
      `TSF_OFF_STAT0: r = TSF_R_STAT0;
      `TSF_OFF_STAT1: r = TSF_R_STAT1;
      `TSF_OFF_STAT2: r = TSF_R_STAT2;
      `TSF_OFF_CNT0: r = TSF_R_CNT0;
      `TSF_OFF_CNT1: r = TSF_R_CNT1;
      `TSF_OFF_CNT2: r = TSF_R_CNT2;
      `TSF_OFF_CTRL: r = TSF_R_CTRL;
      `TSF_OFF_IEN0: r = TSF_R_IEN0;
      `TSF_OFF_IEN1: r = TSF_R_IEN1;
      `TSF_OFF_IEN2: r = TSF_R_IEN2;
      default: r = TSF_R_NONE;
    endcase
    return r;
  endfunction : tsf_reg_of

endpackage : tsf_pkg

// ### rtl/tsf_channel.sv
`timescale 1ns/1ps
`include "tsf_defs.svh"

module tsf_channel
  import tsf_pkg::*;
#(
  parameter bit HAS_PHASE = 1'b0,
  parameter logic [5:0] FLAG_MASK = `TSF_CH0_MASK
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic phase_en,
  input wire logic dir_up,
  input wire logic step,
  input wire logic [3:0] match,
  input wire logic [3:0] capture,
  input wire logic [3:0] cap_mode,
  input wire logic cnt_wr,
  input wire tsf_cnt_t cnt_wdata,
  input wire logic stat_rd,
  input wire logic stat_wr,
  input wire logic [5:0] stat_wdata,
  input wire logic [5:0] irq_en,
  output tsf_cnt_t count,
  output logic [7:0] status,
  output logic [5:0] irq
);

  tsf_cnt_t count_q, count_d;
  logic [5:0] flag_q, flag_d, armed_q, armed_d, irq_q, set_ev, clr_ev;
  logic dir_q;

  // direction is up unless a phase channel in phase mode has dir_up low
  wire step_en = run & step;
  wire up = ~(HAS_PHASE & phase_en) | dir_up;
  wire at_max = (count_q == `TSF_CNT_MAX);
  wire at_min = (count_q == `TSF_CNT_RST);

  // [R21] [R23] software write beats a step
  assign count_d = cnt_wr ? cnt_wdata : !step_en ? count_q :
                   up ? count_q + 16'h0001 : count_q - 16'h0001;

  // [R7] [R8] [R10] [R11] [R13] [R14] [R15] [R16] match or capture
  // [R4] [R9] [R12] unmasked sources only
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_src
    assign set_ev[gi] = FLAG_MASK[gi] & (cap_mode[gi] ? capture[gi] : match[gi]);
  end
  // [R5] overflow on wrap
  assign set_ev[`TSF_BIT_OVF] = FLAG_MASK[`TSF_BIT_OVF] & step_en & ~cnt_wr & up & at_max;
  // [R3] underflow on wrap
  assign set_ev[`TSF_BIT_UNF] = FLAG_MASK[`TSF_BIT_UNF] & step_en & ~cnt_wr & ~up & at_min;

  // [R6] clear needs earlier read
  assign clr_ev = {6{stat_wr}} & ~stat_wdata & armed_q;
  // [R22] set beats clear
  assign flag_d = set_ev | (flag_q & ~clr_ev);
  assign armed_d = flag_d & ~clr_ev & (armed_q | ({6{stat_rd}} & flag_q));

  // [R18] [R20] counter, flags and request flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `TSF_CNT_RST;
      flag_q <= 6'h00;
      armed_q <= 6'h00;
      irq_q <= 6'h00;
      dir_q <= HAS_PHASE & `TSF_DIR_RST;
    end else begin
      count_q <= count_d;
      flag_q <= flag_d;
      armed_q <= armed_d;
      irq_q <= flag_d & irq_en;
      dir_q <= HAS_PHASE & up;
    end
  end

  // [R1] [R2] status byte layout
  assign status = {dir_q, 1'h1, flag_q};
  assign count = count_q;
  assign irq = irq_q;

  // [R5] overflow wrap check
  ovf_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    (step_en && up && at_max && !cnt_wr) |=>
    (flag_q[`TSF_BIT_OVF] && count_q == `TSF_CNT_RST))
    else $error("overflow wrap not flagged");

  // [R3] underflow wrap check
  unf_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    (HAS_PHASE && step_en && !up && at_min && !cnt_wr) |=>
    (flag_q[`TSF_BIT_UNF] && count_q == `TSF_CNT_MAX))
    else $error("underflow wrap not flagged");

  // [R6] clear only after read
  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    ($past(flag_q) & ~flag_q & ~($past(armed_q) & {6{$past(stat_wr)}})) == 6'h00)
    else $error("flag cleared without read of one");

  // [R22] set wins check
  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n) // [R22]
    (set_ev != 6'h00) |=> ((flag_q & $past(set_ev)) == $past(set_ev)))
    else $error("set event lost");

  // [R21] stopped counter holds
  run_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
    (!run && !cnt_wr) |=> $stable(count_q))
    else $error("stopped counter moved");

  // [R2] fixed status bits
  rsv_bits_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    status[`TSF_BIT_RSV] && (HAS_PHASE || !status[`TSF_BIT_DIR]) &&
    ((status[5:0] & ~FLAG_MASK) == 6'h00))
    else $error("fixed status bit wrong");

  // [R20] request follows flag and enable
  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
    1'h1 |=> (irq_q == (flag_q & $past(irq_en))))
    else $error("request not gated by enable");

endmodule : tsf_channel

// ### dv/tsf_testbench.sv
`timescale 1ns/1ps
`include "tsf_defs.svh"

module testbench
  import tsf_pkg::*;
;
  logic clk = 1'b0;
  logic resetn;
  logic [31:0] s_axi_awaddr = 32'h00000000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic s_axi_wready;
  logic [31:0] s_axi_araddr = 32'h00000000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [2:0] count_step = 3'h0;
  logic [2:0] count_up = 3'h7;
  logic [11:0] match_strobe = 12'h000;
  logic [11:0] capture_strobe = 12'h000;
  logic [11:0] capture_mode = 12'h000;
  logic [47:0] count_value;
  logic [23:0] event_status;
  logic [17:0] irq_request;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [1:0] resp;
  logic [31:0] data;

  tsf_top DUT (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .count_step(count_step), .count_up(count_up), .match_strobe(match_strobe),
    .capture_strobe(capture_strobe), .capture_mode(capture_mode),
    .count_value(count_value), .event_status(event_status), .irq_request(irq_request)
  );

  // 10 mhz clock
  always #50 clk = ~clk;

  // verdict and end of run
  task automatic end_sim();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // single comparison point
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // axi write: address and data offered together, each dropped once taken
  task automatic wrs(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wrs

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    wrs(a, d, 4'hF, r);
  endtask : wr

  // axi read; rready held until rvalid is seen
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
  endtask : rd_chk

  // one-cycle timer strobes, then one cycle for the flags to land
  task automatic pulse(input logic [11:0] m, input logic [11:0] c, input logic [2:0] s);
    @(posedge clk);
    match_strobe <= m;
    capture_strobe <= c;
    count_step <= s;
    @(posedge clk);
    match_strobe <= 12'h000;
    capture_strobe <= 12'h000;
    count_step <= 3'h0;
    @(posedge clk);
  endtask : pulse

  // watchdog: the sequence needs well under 3000 cycles
  initial begin
    #(100 * 20000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    // assert at time zero so no flop or check runs on unknown state before the first edge
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(`TSF_OFF_STAT0, 32'h00000040);
    rd_chk(`TSF_OFF_STAT1, 32'h000000C0);
    rd_chk(`TSF_OFF_STAT2, 32'h000000C0);
    chk({16'h0000, count_value[47:32] | count_value[31:16] | count_value[15:0]}, 32'h0);
    wr(`TSF_OFF_STAT0, 32'h000000FF);
    rd_chk(`TSF_OFF_STAT0, 32'h00000040);
    pulse(12'h00F, 12'h000, 3'h0);
    rd_chk(`TSF_OFF_STAT0, 32'h0000004F);
    chk({8'h00, event_status}, 32'h00C0C04F);
    wr(`TSF_OFF_STAT0, 32'h00000000);
    rd_chk(`TSF_OFF_STAT0, 32'h00000040);
    // ch0 c/d follow capture, not match
    capture_mode <= 12'h00C;
    pulse(12'h00C, 12'h000, 3'h0);
    chk({24'h0, event_status[7:0]}, 32'h00000040);
    pulse(12'h000, 12'h00C, 3'h0);
    rd_chk(`TSF_OFF_STAT0, 32'h0000004C);
    wr(`TSF_OFF_STAT0, 32'h00000000);
    capture_mode <= 12'h0F0;
    pulse(12'h000, 12'h0F0, 3'h0);
    rd_chk(`TSF_OFF_STAT1, 32'h000000C3);
    wr(`TSF_OFF_STAT1, 32'h00000000);
    capture_mode <= 12'h000;
    pulse(12'h300, 12'h000, 3'h0);
    wr(`TSF_OFF_STAT2, 32'h00000000);
    chk({24'h0, event_status[23:16]}, 32'h000000C3);
    rd_chk(`TSF_OFF_STAT2, 32'h000000C3);
    wr(`TSF_OFF_STAT2, 32'h000000FF);
    chk({24'h0, event_status[23:16]}, 32'h000000C3);
    wr(`TSF_OFF_STAT2, 32'h00000000);
    rd_chk(`TSF_OFF_STAT2, 32'h000000C0);
    // match on the clearing edge; the write lands one edge after its take
    pulse(12'h100, 12'h000, 3'h0);
    rd_chk(`TSF_OFF_STAT2, 32'h000000C1);
    fork
      wr(`TSF_OFF_STAT2, 32'h00000000);
      begin
        repeat (2) @(posedge clk);
        match_strobe <= 12'h100;
        @(posedge clk);
        match_strobe <= 12'h000;
      end
    join
    chk({24'h0, event_status[23:16]}, 32'h000000C1);
    wr(`TSF_OFF_CNT0, 32'h0000FFFE);
    pulse(12'h000, 12'h000, 3'h1);
    chk({16'h0, count_value[15:0]}, 32'h0000FFFE);
    wr(`TSF_OFF_CTRL, 32'h00000001);
    pulse(12'h000, 12'h000, 3'h1);
    chk({16'h0, count_value[15:0]}, 32'h0000FFFF);
    wr(`TSF_OFF_IEN0, 32'h00000010);
    pulse(12'h000, 12'h000, 3'h1);
    rd_chk(`TSF_OFF_CNT0, 32'h00000000);
    rd_chk(`TSF_OFF_STAT0, 32'h00000050);
    chk({26'h0, irq_request[5:0]}, 32'h00000010);
    wr(`TSF_OFF_IEN0, 32'h00000000);
    // request flop drops one edge after the enable, so let that edge pass
    @(posedge clk);
    chk({26'h0, irq_request[5:0]}, 32'h00000000);
    count_up <= 3'h5;
    wr(`TSF_OFF_CTRL, 32'h00000012);
    pulse(12'h000, 12'h000, 3'h2);
    rd_chk(`TSF_OFF_CNT1, 32'h0000FFFF);
    rd_chk(`TSF_OFF_STAT1, 32'h00000060);
    count_up <= 3'h7;
    pulse(12'h000, 12'h000, 3'h2);
    rd_chk(`TSF_OFF_CNT1, 32'h00000000);
    rd_chk(`TSF_OFF_STAT1, 32'h000000F0);
    wrs(`TSF_OFF_CNT2, 32'h00001234, 4'h1, resp);
    chk({30'h0, resp}, {30'h0, `TSF_RESP_SLVERR});
    rd_chk(`TSF_OFF_CNT2, 32'h00000000);
    wrs(`TSF_OFF_CNT2, 32'h00001234, 4'h3, resp);
    chk({30'h0, resp}, {30'h0, `TSF_RESP_OKAY});
    rd_chk(`TSF_OFF_CNT2, 32'h00001234);
    // unmapped and unaligned places
    rd(32'h00000028, data, resp);
    chk({resp, data[29:0]}, {`TSF_RESP_SLVERR, 30'h0});
    wrs(32'h00000002, 32'h00000000, 4'hF, resp);
    chk({30'h0, resp}, {30'h0, `TSF_RESP_SLVERR});
    end_sim();
  end
endmodule : testbench
